// ==== pkg/pab_pkg.sv ====
// constants and helpers shared by the pipeline converter digital back end
// Functional notes
// - result appears seven clocks after its sample
// - one new word every clock after latency
// - eight redundant stages plus one flash stage
// - delay line aligns stage codes into eighteen bits
// - correction merges raw word into ten bits
// - each stage clock inverts the previous one
// - two non-overlapping phases from master clock
// - two cascaded output latches retime the word
// - format select picks output encoding
// - offset binary spans zeros to all ones
// - two's complement inverts only the msb
// - format select low offset, high two's complement
// - output enable high floats the data outputs
package pab_pkg;
   localparam int RESULT_W = 10;
   localparam int CODE_W = 2;
   localparam int STAGE_CNT = 8;
   localparam int RAW_W = 18;
   localparam int SUM_W = 11;
   localparam int RESULT_MSB_POS = 9;
   localparam int LATENCY_CYC = 7;
   localparam int WARMUP_CYC = 20;
   localparam int ALIGN_BASE_CYC = 4;
   localparam int CNT_W = 5;
   localparam logic [RESULT_W-1:0] RESULT_MAX = 10'h3ff;
   localparam logic [RESULT_W-1:0] RESULT_RST = 10'h000;
   localparam logic [CODE_W-1:0] STAGE_CODE_MAX = 2'h2;
   localparam logic OUTPUT_FORMAT_OFFSET = 1'b0;
   localparam logic OUTPUT_FORMAT_TWOS = 1'b1;

   // stage k resolves (k/2)+1 clocks after the sample; pairs share a clock because of the inverted phases
   function automatic int pab_align_depth(input int k);
      return ALIGN_BASE_CYC - (k / 2);
   endfunction

   function automatic logic [RESULT_W-1:0] pab_encode(input logic [RESULT_W-1:0] off_bin, input logic fmt);
      logic [RESULT_W-1:0] w;
      w = off_bin;
      if (fmt == OUTPUT_FORMAT_TWOS) begin
         w[RESULT_MSB_POS] = ~off_bin[RESULT_MSB_POS];
      end
      return w;
   endfunction
endpackage

// ==== hdl/pab_delay_line.sv ====
// clocked delay line for one stage code
`timescale 1ns/1ps
`default_nettype none
module pab_delay_line
   import pab_pkg::*;
#(
   parameter int WIDTH = 2,
   parameter int DEPTH = 4
) (
   input wire logic clk_sys_in, // master sample clock
   input wire logic rst_in, // async reset, high
   input wire logic [WIDTH-1:0] data_in, // code entering the line
   output logic [WIDTH-1:0] data_out // code DEPTH clocks later
);
   logic [WIDTH-1:0] tap_reg [DEPTH];
   logic [WIDTH-1:0] tap_next [DEPTH];

   always_comb begin
      tap_next[0] = data_in;
      for (int i = 1; i < DEPTH; i++) begin
         tap_next[i] = tap_reg[i-1];
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            tap_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            tap_reg[i] <= tap_next[i];
         end
      end
   end

   assign data_out = tap_reg[DEPTH-1];

   delay_exact_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      tap_reg[DEPTH-1] == $past(data_in, DEPTH) || $past(rst_in, DEPTH))
      else $error("delay line depth wrong");
endmodule // pab_delay_line
`default_nettype wire

// ==== hdl/pab_backend.sv ====
// digital back end: phase generation, alignment, correction, output latches
`timescale 1ns/1ps
`default_nettype none
module pab_backend
   import pab_pkg::*;
(
   input wire logic clk_sys_in, // master sample clock
   input wire logic rst_in, // async reset, high
   input wire logic [STAGE_CNT*CODE_W-1:0] stage_code_in, // stage k code at bits 2k+1:2k
   input wire logic [CODE_W-1:0] flash_code_in, // ninth stage flash code
   input wire logic output_format_select, // low offset binary, high two's complement
   input wire logic output_enable_n_in, // low drives the data bus
   output logic phase_1_out, // sampling phase
   output logic phase_2_out, // transfer phase
   output logic [STAGE_CNT:0] stage_clk_out, // per-stage clock, alternating
   output logic [RESULT_W-1:0] data_out, // result_msb is bit 9, result_lsb bit 0
   output logic data_oe_out, // high while the data bus is driven
   output logic words_valid_out, // pipeline filled
   output logic warmup_done_out // warmup clocks elapsed
);
   // ---------------- phase generation
   logic phase_reg;
   logic phase_next;
   logic phi1_reg;
   logic phi1_next;
   logic phi2_reg;
   logic phi2_next;

   always_comb begin
      phase_next = ~phase_reg;
      // both phases follow the one phase register, so they can never overlap;
      // phase 2 waits for a first phase 1, which leaves one dead clock after reset
      phi1_next = phase_reg;
      phi2_next = ~phase_reg & (phi1_reg | phi2_reg);
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         phase_reg <= 1'b0;
         phi1_reg <= 1'b0;
         phi2_reg <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         phi1_reg <= phi1_next;
         phi2_reg <= phi2_next;
      end
   end

   assign phase_1_out = phi1_reg;
   assign phase_2_out = phi2_reg;

   genvar g;
   generate
      for (g = 0; g <= STAGE_CNT; g++) begin : g_stage_clk
         assign stage_clk_out[g] = (g % 2 == 0) ? phase_reg : ~phase_reg;
      end
   endgenerate

   phase_nonoverlap_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !(phi1_reg && phi2_reg))
      else $error("phases overlap");

   phase_alternate_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      phi1_reg |=> !phi1_reg ##1 phi1_reg)
      else $error("sampling phase does not alternate");

   stage_clk_invert_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      stage_clk_out[STAGE_CNT:1] == ~stage_clk_out[STAGE_CNT-1:0] && ($changed(stage_clk_out[0]) || $past(rst_in)))
      else $error("neighbour stage clocks not inverted");

   // ---------------- alignment delay line
   logic [RAW_W-1:0] raw_aligned;

   generate
      for (g = 0; g < STAGE_CNT; g++) begin : g_align
         pab_delay_line #(
            .WIDTH(CODE_W),
            .DEPTH(pab_align_depth(g))
         ) u_line (
            .clk_sys_in(clk_sys_in),
            .rst_in(rst_in),
            .data_in(stage_code_in[g*CODE_W +: CODE_W]),
            .data_out(raw_aligned[RAW_W-1-g*CODE_W -: CODE_W])
         );
      end
   endgenerate
   assign raw_aligned[CODE_W-1:0] = flash_code_in;

   // ---------------- error correction
   function automatic logic [RESULT_W-1:0] pab_correct(input logic [RAW_W-1:0] raw);
      logic [SUM_W-1:0] sum;
      logic [CODE_W-1:0] c;
      sum = {{(SUM_W-CODE_W){1'b0}}, raw[CODE_W-1:0]};
      for (int k = 0; k < STAGE_CNT; k++) begin
         c = raw[RAW_W-1-k*CODE_W -: CODE_W];
         // a redundant stage never legally reports 3; clamp so a stray code cannot wrap
         if (c > STAGE_CODE_MAX) begin
            c = STAGE_CODE_MAX;
         end
         sum = sum + SUM_W'({{(SUM_W-CODE_W){1'b0}}, c} << (STAGE_CNT - k));
      end
      if (sum > {1'b0, RESULT_MAX}) begin
         return RESULT_MAX;
      end
      return sum[RESULT_W-1:0];
   endfunction

   logic [RESULT_W-1:0] corr_word;
   assign corr_word = pab_correct(raw_aligned);

   correct_fullscale_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (raw_aligned == {{STAGE_CNT{STAGE_CODE_MAX}}, 2'h3}) |-> corr_word == RESULT_MAX)
      else $error("full scale codes do not correct to all ones");

   correct_zero_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (raw_aligned == '0) |-> corr_word == RESULT_RST)
      else $error("zero codes do not correct to zero");

   // ---------------- output latches
   logic [RESULT_W-1:0] latch1_reg;
   logic [RESULT_W-1:0] latch1_next;
   logic [RESULT_W-1:0] latch2_reg;
   logic [RESULT_W-1:0] latch2_next;

   always_comb begin
      latch1_next = pab_encode(corr_word, output_format_select);
      latch2_next = latch1_reg;
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         latch1_reg <= RESULT_RST;
         latch2_reg <= RESULT_RST;
      end else begin
         latch1_reg <= latch1_next;
         latch2_reg <= latch2_next;
      end
   end

   assign data_out = latch2_reg;
   // the enable follows the pin directly; the word itself stays registered
   assign data_oe_out = ~output_enable_n_in;

   out_latency_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      words_valid_out && $past(words_valid_out, 2) && !$past(output_format_select, 2)
      |-> data_out[0] == $past(flash_code_in[0], 2))
      else $error("flash lsb not on bus two clocks later");

   out_offset_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $past(output_format_select, 2) == OUTPUT_FORMAT_OFFSET && !$past(rst_in, 2) && !$past(rst_in)
      |-> data_out == $past(corr_word, 2))
      else $error("offset binary word differs from corrected word");

   out_twos_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $past(output_format_select, 2) == OUTPUT_FORMAT_TWOS && !$past(rst_in, 2) && !$past(rst_in)
      |-> data_out == {~$past(corr_word[RESULT_MSB_POS], 2), $past(corr_word[RESULT_MSB_POS-1:0], 2)})
      else $error("two's complement word is not msb-inverted");

   out_float_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      output_enable_n_in |-> !data_oe_out)
      else $error("bus driven while disabled");

   // ---------------- fill and warmup tracking
   logic [CNT_W-1:0] clk_cnt_reg;
   logic [CNT_W-1:0] clk_cnt_next;

   always_comb begin
      clk_cnt_next = clk_cnt_reg;
      // saturate so the flags never fall back after a long run
      if (clk_cnt_reg < CNT_W'(WARMUP_CYC)) begin
         clk_cnt_next = clk_cnt_reg + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         clk_cnt_reg <= '0;
      end else begin
         clk_cnt_reg <= clk_cnt_next;
      end
   end

   assign words_valid_out = clk_cnt_reg >= CNT_W'(LATENCY_CYC);
   assign warmup_done_out = clk_cnt_reg >= CNT_W'(WARMUP_CYC);

   valid_sticky_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      words_valid_out |=> words_valid_out)
      else $error("valid flag dropped");

   valid_time_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $rose(words_valid_out) |-> $past(clk_cnt_reg) == CNT_W'(LATENCY_CYC - 1))
      else $error("valid flag at wrong count");
endmodule // pab_backend
`default_nettype wire

// ==== test/pab_capture_model.sv ====
// downstream capture model for the converter output bus
`timescale 1ns/1ps
`default_nettype none
module pab_capture_model
   import pab_pkg::*;
(
   input wire logic clk_in, // bus capture clock
   input wire logic rst_in, // async reset, high
   input wire logic [RESULT_W-1:0] data_in, // device data pins
   input wire logic oe_in, // device drives the bus
   output logic [RESULT_W-1:0] word_out, // last captured word
   output logic [15:0] cap_cnt_out // words accepted
);
   logic [RESULT_W-1:0] bus_reg;
   logic [CNT_W-1:0] age_reg;
   wire logic [RESULT_W-1:0] bus_w;
   // a floated bus must not look like the last word
   assign bus_w = oe_in ? data_in : ~bus_reg;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         bus_reg <= '0;
         age_reg <= '0;
         word_out <= '0;
         cap_cnt_out <= '0;
      end else begin
         bus_reg <= bus_w;
         if (age_reg != CNT_W'(WARMUP_CYC)) begin
            age_reg <= age_reg + CNT_W'(1);
         end else if (oe_in) begin
            // fill and warmup words are dropped by waiting out warmup
            word_out <= bus_w;
            cap_cnt_out <= cap_cnt_out + 16'h1;
         end
      end
   end
endmodule // pab_capture_model
`default_nettype wire

// ==== test/pab_backend_tb_top.sv ====
// self-checking bench for the converter digital back end
`timescale 1ns/1ps
`default_nettype none
module pab_backend_tb_top;
   import pab_pkg::*;
   localparam int NS = 8;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic [15:0] stage_code_in = '0;
   logic [1:0] flash_code_in = '0;
   logic output_format_select = 1'b0;
   logic output_enable_n_in = 1'b0;
   logic phase_1_out, phase_2_out, data_oe_out, words_valid_out, warmup_done_out;
   logic [8:0] stage_clk_out;
   logic [9:0] data_out, cap_word;
   logic [15:0] cap_cnt;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [15:0] st_tab [NS] = '{16'haaaa, 16'haaaa, 16'h0, 16'h0, 16'h2, 16'h2, 16'haaa8, 16'hffff};
   logic [1:0] fl_tab [NS] = '{2'h3, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h3};
   logic [7:0] fm_bits = 8'h2a;

   pab_backend u_pab_backend (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .stage_code_in(stage_code_in),
      .flash_code_in(flash_code_in), .output_format_select(output_format_select),
      .output_enable_n_in(output_enable_n_in), .phase_1_out(phase_1_out), .phase_2_out(phase_2_out),
      .stage_clk_out(stage_clk_out), .data_out(data_out), .data_oe_out(data_oe_out),
      .words_valid_out(words_valid_out), .warmup_done_out(warmup_done_out));
   pab_capture_model u_pab_capture_model (.clk_in(clk_sys_in), .rst_in(rst_in), .data_in(data_out),
      .oe_in(data_oe_out), .word_out(cap_word), .cap_cnt_out(cap_cnt));

   always #20 clk_sys_in = ~clk_sys_in;

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 400) begin
         err_count++;
         give_verdict();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [9:0] exp_word(input int n);
      int s;
      logic [1:0] c;
      logic [9:0] w;
      s = int'(fl_tab[n]);
      for (int k = 0; k < 8; k++) begin
         c = st_tab[n][2*k +: 2];
         if (c == 2'h3) c = 2'h2;
         s = s + (int'(c) << (8 - k));
      end
      if (s > 1023) s = 1023;
      w = s[9:0];
      if (fm_bits[n]) w[9] = ~w[9];
      return w;
   endfunction

   task automatic t_reset_flags();
      logic p1_prev;
      rst_in = 1'b1;
      repeat (8) @(negedge clk_sys_in);
      chk("data in reset", 16'h0, {6'h0, data_out});
      rst_in = 1'b0;
      p1_prev = 1'b0;
      for (int i = 1; i <= 21; i++) begin
         @(negedge clk_sys_in);
         chk("phase overlap", 16'h0, {15'h0, phase_1_out & phase_2_out});
         chk("stage clock chain", 16'hff, {8'h0, stage_clk_out[8:1] ^ stage_clk_out[7:0]});
         if (i >= 3) chk("phase 1 toggle", {15'h0, ~p1_prev}, {15'h0, phase_1_out});
         if (i >= 3) chk("phase 2", {15'h0, ~phase_1_out}, {15'h0, phase_2_out});
         if (i == 6 || i == 8) chk("words valid", 16'(i / 8), {15'h0, words_valid_out});
         if (i == 19 || i == 21) chk("warmup done", 16'(i / 21), {15'h0, warmup_done_out});
         p1_prev = phase_1_out;
      end
   endtask

   // stage codes arrive staggered as the alternating stage clocks resolve them
   task automatic t_stream();
      int n;
      logic [15:0] sv;
      for (int e = 0; e < NS + 8; e++) begin
         for (int k = 0; k < 8; k++) begin
            n = e - 1 - k / 2;
            sv[2*k +: 2] = (n >= 0 && n < NS) ? st_tab[n][2*k +: 2] : 2'h0;
         end
         stage_code_in = sv;
         n = e - 5;
         flash_code_in = (n >= 0 && n < NS) ? fl_tab[n] : 2'h0;
         output_format_select = (n >= 0 && n < NS) ? fm_bits[n] : 1'b0;
         @(negedge clk_sys_in);
         // sample n's word stands on the bus after edge n+6 and is captured at edge n+7
         if (e >= 6 && e < NS + 6) chk("data word", {6'h0, exp_word(e - 6)}, {6'h0, data_out});
         if (e >= 7 && e < NS + 7) chk("captured word", {6'h0, exp_word(e - 7)}, {6'h0, cap_word});
      end
   endtask

   task automatic t_oe();
      logic [15:0] c0;
      output_enable_n_in = 1'b1;
      #1;
      chk("oe off", 16'h0, {15'h0, data_oe_out});
      c0 = cap_cnt;
      repeat (3) @(negedge clk_sys_in);
      chk("no capture floated", c0, cap_cnt);
      output_enable_n_in = 1'b0;
      #1;
      chk("oe on", 16'h1, {15'h0, data_oe_out});
      repeat (3) @(negedge clk_sys_in);
      chk("capture resumes", c0 + 16'h3, cap_cnt);
   endtask

   initial begin
      t_reset_flags();
      t_stream();
      t_oe();
      give_verdict();
   end
endmodule // pab_backend_tb_top
`default_nettype wire
